// *** logic/motor_protect_pkg.sv ***
// constants for the motor overload and stall protection block
`default_nettype none
package motor_protect_pkg;
    localparam int CLOCK_MHZ            = 250;
    localparam int TICK_PERIOD_MS       = 100;
    localparam int TICK_CYCLES          = TICK_PERIOD_MS * 1000 * CLOCK_MHZ;
    localparam int THERMAL_WINDOW_MS    = 60000;
    localparam int THERMAL_WINDOW_TICKS = THERMAL_WINDOW_MS / TICK_PERIOD_MS;

    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] RATED_OFFSET  = 8'h04;
    localparam logic [7:0] THERM_OFFSET  = 8'h08;
    localparam logic [7:0] WARN_OFFSET   = 8'h0c;
    localparam logic [7:0] TRIP_OFFSET   = 8'h10;
    localparam logic [7:0] STALL_OFFSET  = 8'h14;
    localparam logic [7:0] STATUS_OFFSET = 8'h18;
    localparam logic [7:0] ACCUM_OFFSET  = 8'h1c;

    localparam int CTRL_THERM_SEL_BIT   = 0;
    localparam int CTRL_FORCED_COOL_BIT = 1;
    localparam int CTRL_SENSORLESS_BIT  = 2;
    localparam int CTRL_STALL_LSB       = 4;
    localparam int CTRL_AUX_OL_BIT      = 8;
    localparam int CTRL_CLEAR_BIT       = 16;
    localparam int LEVEL_LSB            = 0;
    localparam int UPPER_LSB            = 8;

    localparam logic [31:0] CTRL_MASK  = 32'h0000_0177;
    localparam logic [31:0] RATED_MASK = 32'h0000_ffff;
    localparam logic [31:0] THERM_MASK = 32'h0000_ffff;
    localparam logic [31:0] TIME_MASK  = 32'h00ff_ffff;
    localparam logic [31:0] STALL_MASK = 32'h0000_ffff;

    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] RATED_RST = 32'h0000_0064;
    localparam logic [31:0] THERM_RST = 32'h0000_6496;
    localparam logic [31:0] WARN_RST  = 32'h0000_6496;
    localparam logic [31:0] TRIP_RST  = 32'h0002_58b4;
    localparam logic [31:0] STALL_RST = 32'h0000_00b4;

    localparam logic [15:0] FULL_PCT         = 16'h0064;
    localparam logic [15:0] DERATE_FLOOR_PCT = 16'h0046;
    localparam logic [15:0] DERATE_SPAN_PCT  = 16'h001e;
    localparam logic [9:0]  PCT_CLAMP        = 10'h3ff;
endpackage
`default_nettype wire

// *** logic/motor_overload_stall_protect.sv ***
// motor thermal model, overload alarm and trip, stall prevention, energy save
`default_nettype none
module motor_overload_stall_protect #(
    parameter int TICK_CYCLES = motor_protect_pkg::TICK_CYCLES
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic [15:0] MOTOR_CURRENT,
    input  wire logic [7:0]  SPEED_PCT,
    input  wire logic        ACCELERATING,
    input  wire logic        DECELERATING,
    input  wire logic        AT_REFERENCE,
    output logic             OUTPUT_OFF,
    output logic             THERMAL_TRIP,
    output logic             OVERLOAD_FAULT,
    output logic             OVERLOAD_ALARM,
    output logic             AUX_RELAY_OUTPUT,
    output logic             STALL_REDUCE,
    output logic      [7:0]  VOLT_REDUCE_PCT
);
    logic [31:0] ctrl_reg, rated_reg, therm_reg, warn_reg, trip_reg, stall_reg;
    logic [31:0] tick_cnt_reg, accum_reg, dat_reg;
    logic [15:0] warn_cnt_reg, hold_cnt_reg, trip_cnt_reg;
    logic        ack_reg, alarm_reg, thermal_reg, fault_reg, stall_reg_q;
    logic [7:0]  volt_reg;
    logic        tick, access, wr, clear;
    logic        therm_sel, forced, sensorless, aux_ol;
    logic [2:0]  stall_mode_bits;
    logic [15:0] rated, warn_time, trip_time;
    logic [7:0]  one_min_lvl, cont_lvl, warn_lvl, trip_lvl, stall_lvl, energy_save_level;
    logic [22:0] cur_x100, quot;
    logic [9:0]  pct;
    logic [15:0] derate, cont_der, min_der;
    logic [31:0] heat, cool, limit, accum_next;
    logic        over_warn, over_trip, over_stall, warn_reached, trip_reached, thermal_hit;
    logic        steady, phase_en, esave_ok;

    // byte-lane merge, unimplemented bits forced to zero
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] sel, input logic [31:0] mask);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) res[8*i +: 8] = new_v[8*i +: 8];
        end
        return res & mask;
    endfunction

    // level check against percent of rated current without a divider
    function automatic logic at_or_above(input logic [22:0] cur, input logic [7:0] lvl, input logic [15:0] r);
        return {1'b0, cur} >= 24'(lvl) * 24'(r);
    endfunction

    assign therm_sel         = ctrl_reg[motor_protect_pkg::CTRL_THERM_SEL_BIT];
    assign forced            = ctrl_reg[motor_protect_pkg::CTRL_FORCED_COOL_BIT];
    assign sensorless        = ctrl_reg[motor_protect_pkg::CTRL_SENSORLESS_BIT];
    assign aux_ol            = ctrl_reg[motor_protect_pkg::CTRL_AUX_OL_BIT];
    assign stall_mode_bits   = ctrl_reg[motor_protect_pkg::CTRL_STALL_LSB +: 3];
    assign rated             = rated_reg[15:0];
    assign one_min_lvl       = therm_reg[motor_protect_pkg::LEVEL_LSB +: 8];
    assign cont_lvl          = therm_reg[motor_protect_pkg::UPPER_LSB +: 8];
    assign warn_lvl          = warn_reg[motor_protect_pkg::LEVEL_LSB +: 8];
    assign warn_time         = warn_reg[motor_protect_pkg::UPPER_LSB +: 16];
    assign trip_lvl          = trip_reg[motor_protect_pkg::LEVEL_LSB +: 8];
    assign trip_time         = trip_reg[motor_protect_pkg::UPPER_LSB +: 16];
    assign stall_lvl         = stall_reg[motor_protect_pkg::LEVEL_LSB +: 8];
    assign energy_save_level = stall_reg[motor_protect_pkg::UPPER_LSB +: 8];

    // wishbone classic slave: one wait state, unmapped reads give zero
    assign access = CYC_I && STB_I && !ack_reg;
    // writes land at the edge where the master samples ack, never before
    assign wr     = CYC_I && STB_I && WE_I && ack_reg;
    assign clear  = wr && ADR_I == motor_protect_pkg::CTRL_OFFSET && SEL_I[2]
                    && DAT_I[motor_protect_pkg::CTRL_CLEAR_BIT];

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ack_reg <= 1'b0;
        end else if (CE) begin
            ack_reg <= access;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctrl_reg  <= motor_protect_pkg::CTRL_RST;
            rated_reg <= motor_protect_pkg::RATED_RST;
            therm_reg <= motor_protect_pkg::THERM_RST;
            warn_reg  <= motor_protect_pkg::WARN_RST;
            trip_reg  <= motor_protect_pkg::TRIP_RST;
            stall_reg <= motor_protect_pkg::STALL_RST;
        end else if (CE && wr) begin
            case (ADR_I)
                motor_protect_pkg::CTRL_OFFSET: begin
                    ctrl_reg <= merge_bytes(ctrl_reg, DAT_I, SEL_I, motor_protect_pkg::CTRL_MASK);
                end
                motor_protect_pkg::RATED_OFFSET: begin
                    rated_reg <= merge_bytes(rated_reg, DAT_I, SEL_I, motor_protect_pkg::RATED_MASK);
                end
                motor_protect_pkg::THERM_OFFSET: begin
                    therm_reg <= merge_bytes(therm_reg, DAT_I, SEL_I, motor_protect_pkg::THERM_MASK);
                end
                motor_protect_pkg::WARN_OFFSET: begin
                    warn_reg <= merge_bytes(warn_reg, DAT_I, SEL_I, motor_protect_pkg::TIME_MASK);
                end
                motor_protect_pkg::TRIP_OFFSET: begin
                    trip_reg <= merge_bytes(trip_reg, DAT_I, SEL_I, motor_protect_pkg::TIME_MASK);
                end
                motor_protect_pkg::STALL_OFFSET: begin
                    stall_reg <= merge_bytes(stall_reg, DAT_I, SEL_I, motor_protect_pkg::STALL_MASK);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            dat_reg <= 32'h0;
        end else if (CE && access && !WE_I) begin
            case (ADR_I)
                motor_protect_pkg::CTRL_OFFSET:   dat_reg <= ctrl_reg;
                motor_protect_pkg::RATED_OFFSET:  dat_reg <= rated_reg;
                motor_protect_pkg::THERM_OFFSET:  dat_reg <= therm_reg;
                motor_protect_pkg::WARN_OFFSET:   dat_reg <= warn_reg;
                motor_protect_pkg::TRIP_OFFSET:   dat_reg <= trip_reg;
                motor_protect_pkg::STALL_OFFSET:  dat_reg <= stall_reg;
                motor_protect_pkg::STATUS_OFFSET: begin
                    dat_reg <= {26'h0, volt_reg != 8'h0, stall_reg_q, alarm_reg, fault_reg, thermal_reg, OUTPUT_OFF};
                end
                motor_protect_pkg::ACCUM_OFFSET:  dat_reg <= accum_reg;
                default:                          dat_reg <= 32'h0;
            endcase
        end
    end

    // periodic time base for every level-and-duration check
    assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            tick_cnt_reg <= 32'h0;
        end else if (CE) begin
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
        end
    end

    // current as percent of rated; zero rating gives zero percent, so only the thermal model reads it as no current
    assign cur_x100 = 23'(MOTOR_CURRENT) * 23'h64;
    assign quot     = (rated == 16'h0) ? 23'h0 : cur_x100 / 23'(rated);
    assign pct      = (quot > 23'(motor_protect_pkg::PCT_CLAMP)) ? motor_protect_pkg::PCT_CLAMP : quot[9:0];

    // self-cooled: 70 % allowance at standstill rising to 100 % at full speed
    always_comb begin
        if (forced || 16'(SPEED_PCT) >= motor_protect_pkg::FULL_PCT) begin
            derate = motor_protect_pkg::FULL_PCT;
        end else begin
            derate = motor_protect_pkg::DERATE_FLOOR_PCT
                     + 16'(16'(SPEED_PCT) * motor_protect_pkg::DERATE_SPAN_PCT / motor_protect_pkg::FULL_PCT);
        end
    end

    assign cont_der = 16'(16'(cont_lvl) * derate / motor_protect_pkg::FULL_PCT);
    assign min_der  = 16'(16'(one_min_lvl) * derate / motor_protect_pkg::FULL_PCT);
    assign heat     = 32'(pct) * 32'(pct);
    assign cool     = 32'(cont_der) * 32'(cont_der);
    // budget above the continuous level equals one minute at the one-minute level
    assign limit    = (min_der > cont_der) ? (32'(min_der) * 32'(min_der) - cool)
                      * 32'(motor_protect_pkg::THERMAL_WINDOW_TICKS) : 32'h0;

    always_comb begin
        if (heat >= cool) begin
            accum_next = (accum_reg + (heat - cool) < accum_reg) ? 32'hffff_ffff : accum_reg + (heat - cool);
        end else begin
            accum_next = (accum_reg > cool - heat) ? accum_reg - (cool - heat) : 32'h0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            accum_reg <= 32'h0;
        end else if (CE) begin
            if (!therm_sel) begin
                accum_reg <= 32'h0;
            end else if (tick) begin
                accum_reg <= accum_next;
            end
        end
    end

    // zero accumulator never trips, so a misconfigured zero budget stays quiet only until a tick heats above the continuous level
    assign thermal_hit = therm_sel && accum_reg != 32'h0 && accum_reg >= limit;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            thermal_reg <= 1'b0;
        end else if (CE) begin
            if (thermal_hit) begin
                thermal_reg <= 1'b1;
            end else if (clear) begin
                thermal_reg <= 1'b0;
            end
        end
    end

    assign over_warn    = at_or_above(cur_x100, warn_lvl, rated);
    assign over_trip    = {1'b0, cur_x100} > 24'(trip_lvl) * 24'(rated);
    assign over_stall   = {1'b0, cur_x100} > 24'(stall_lvl) * 24'(rated);
    assign warn_reached = over_warn && warn_cnt_reg >= warn_time;
    assign trip_reached = over_trip && trip_cnt_reg >= trip_time;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            warn_cnt_reg <= 16'h0;
            trip_cnt_reg <= 16'h0;
        end else if (CE) begin
            if (!over_warn) begin
                warn_cnt_reg <= 16'h0;
            end else if (tick && warn_cnt_reg != 16'hffff) begin
                warn_cnt_reg <= warn_cnt_reg + 16'h1;
            end
            if (!over_trip) begin
                trip_cnt_reg <= 16'h0;
            end else if (tick && trip_cnt_reg != 16'hffff) begin
                trip_cnt_reg <= trip_cnt_reg + 16'h1;
            end
        end
    end

    // alarm is advisory only: it feeds no shutdown path
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            alarm_reg    <= 1'b0;
            hold_cnt_reg <= 16'h0;
        end else if (CE) begin
            if (warn_reached) begin
                alarm_reg    <= 1'b1;
                hold_cnt_reg <= warn_time;
            end else if (hold_cnt_reg != 16'h0) begin
                if (tick) hold_cnt_reg <= hold_cnt_reg - 16'h1;
            end else begin
                alarm_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            fault_reg <= 1'b0;
        end else if (CE) begin
            if (trip_reached) begin
                fault_reg <= 1'b1;
            end else if (clear) begin
                fault_reg <= 1'b0;
            end
        end
    end

    // frequency path lowers output and holds its ramp while this is high
    assign steady   = AT_REFERENCE && !ACCELERATING && !DECELERATING;
    assign phase_en = (ACCELERATING && stall_mode_bits[0]) || (steady && stall_mode_bits[1])
                      || (DECELERATING && stall_mode_bits[2]);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            stall_reg_q <= 1'b0;
        end else if (CE) begin
            stall_reg_q <= phase_en && over_stall;
        end
    end

    assign esave_ok = steady && energy_save_level != 8'h0 && !sensorless;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            volt_reg <= 8'h0;
        end else if (CE) begin
            volt_reg <= esave_ok ? energy_save_level : 8'h0;
        end
    end

    assign DAT_O            = dat_reg;
    assign ACK_O            = ack_reg;
    assign THERMAL_TRIP     = thermal_reg;
    assign OVERLOAD_FAULT   = fault_reg;
    assign OUTPUT_OFF       = thermal_reg || fault_reg;
    assign OVERLOAD_ALARM   = alarm_reg;
    assign AUX_RELAY_OUTPUT = alarm_reg && aux_ol;
    assign STALL_REDUCE     = stall_reg_q;
    assign VOLT_REDUCE_PCT  = volt_reg;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    chk_esave_zero_level: assert property (CE && energy_save_level == 8'h0 |=> VOLT_REDUCE_PCT == 8'h0)
        else $error("energy save active at zero level");
    chk_esave_sensorless: assert property (CE && sensorless |=> VOLT_REDUCE_PCT == 8'h0)
        else $error("energy save active in sensorless mode");
    chk_esave_steady_only: assert property (CE && (ACCELERATING || DECELERATING || !AT_REFERENCE)
                                            |=> VOLT_REDUCE_PCT == 8'h0)
        else $error("energy save active off steady speed");
    chk_thermal_needs_select: assert property ($rose(thermal_reg) |-> $past(therm_sel)
                                               && $past(thermal_hit))
        else $error("thermal trip without selection or budget");
    chk_warn_alarm_cause: assert property ($rose(alarm_reg) |-> $past(warn_reached))
        else $error("alarm without sustained overload");
    chk_alarm_hold_time: assert property (alarm_reg && hold_cnt_reg != 16'h0 |=> alarm_reg)
        else $error("alarm dropped before hold time");
    chk_aux_select_gate: assert property (!aux_ol |-> !AUX_RELAY_OUTPUT)
        else $error("aux relay driven without overload choice");
    chk_fault_cause: assert property ($rose(fault_reg) |-> $past(trip_reached))
        else $error("overload fault without sustained overload");
    chk_output_off_trip: assert property ($rose(OUTPUT_OFF) |-> $past(thermal_hit) || $past(trip_reached))
        else $error("output shut off without a trip cause");
    chk_stall_phase_gate: assert property (CE && !phase_en |=> !STALL_REDUCE)
        else $error("stall reduction in disabled phase");
    chk_stall_reduce_on: assert property (CE && phase_en && over_stall |=> STALL_REDUCE)
        else $error("stall reduction missing above level");
    chk_tick_spacing: assert property (CE && tick && TICK_CYCLES > 1 |=> !tick)
        else $error("tick repeated on consecutive cycles");
    chk_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    chk_stall_release: assert property (CE && !over_stall |=> !STALL_REDUCE)
        else $error("stall reduction kept below level");
    chk_thermal_off_clear: assert property (CE && !therm_sel |=> accum_reg == 32'h0)
        else $error("accumulator kept with thermal model off");
    chk_thermal_latched: assert property (thermal_reg && !clear |=> thermal_reg)
        else $error("thermal trip dropped without clear");
    chk_fault_latched: assert property (fault_reg && !clear |=> fault_reg)
        else $error("overload fault dropped without clear");
    chk_warn_count_reset: assert property (CE && !over_warn |=> warn_cnt_reg == 16'h0)
        else $error("warn timer kept below warn level");
    chk_trip_count_reset: assert property (CE && !over_trip |=> trip_cnt_reg == 16'h0)
        else $error("trip timer kept below trip level");

    cov_alarm_rise:   cover property ($rose(alarm_reg));
    cov_thermal_trip: cover property ($rose(thermal_reg));
    cov_ol_fault:     cover property ($rose(fault_reg));
    cov_stall_active: cover property ($rose(STALL_REDUCE));
    cov_esave_on:     cover property (CE && esave_ok);
endmodule
`default_nettype wire

// *** tb/motor_drive_model.sv ***
// drive-side model: current sensor, speed and ramp phase feedback
`default_nettype none
module motor_drive_model (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [15:0] load_current,
    input  wire logic [7:0]  speed_cmd,
    input  wire logic [1:0]  phase_cmd,
    input  wire logic        output_off,
    output logic      [15:0] motor_current,
    output logic      [7:0]  speed_pct,
    output logic             accelerating,
    output logic             decelerating,
    output logic             at_reference
);
    timeunit 1ns;
    timeprecision 1ps;
    // phase_cmd: 0 accel, 1 steady, 2 decel, 3 idle
    always_ff @(posedge clock) begin
        // no output voltage means no motor current
        motor_current <= (rst || output_off) ? 16'h0000 : load_current;
        speed_pct     <= speed_cmd;
        accelerating  <= phase_cmd == 2'h0;
        at_reference  <= phase_cmd == 2'h1;
        decelerating  <= phase_cmd == 2'h2;
    end
endmodule
`default_nettype wire

// *** tb/test_motor_overload_stall_protect.sv ***
// self-checking bench for the motor protection block
`default_nettype none
module test_motor_overload_stall_protect;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    logic        clock = 1'b0;
    logic        rst   = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] wdat  = 32'h0;
    logic [3:0]  sel   = 4'h0;
    logic [3:0]  lanes = 4'hf;
    logic        ce    = 1'b1;
    logic [15:0] load  = 16'h0;
    logic [7:0]  speed = 8'h64;
    logic [1:0]  phase = 2'h3;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic [15:0] cur;
    logic [7:0]  spd;
    logic [7:0]  vred;
    logic        acc, dec, atref, off, ttrip, fault, alarm, aux, stall;
    int          bad_count = 0;
    int          comparisons = 0;
    logic [31:0] rst_vals [6] = '{32'h0, 32'h64, 32'h6496, 32'h6496, 32'h258b4, 32'hb4};

    always #2 clock = ~clock;

    motor_overload_stall_protect #(.TICK_CYCLES(TICK)) u_dut (
        .CLOCK(clock), .RST(rst), .CE(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .MOTOR_CURRENT(cur), .SPEED_PCT(spd),
        .ACCELERATING(acc), .DECELERATING(dec), .AT_REFERENCE(atref), .OUTPUT_OFF(off),
        .THERMAL_TRIP(ttrip), .OVERLOAD_FAULT(fault), .OVERLOAD_ALARM(alarm),
        .AUX_RELAY_OUTPUT(aux), .STALL_REDUCE(stall), .VOLT_REDUCE_PCT(vred));

    motor_drive_model u_drive (
        .clock(clock), .rst(rst), .load_current(load), .speed_cmd(speed), .phase_cmd(phase),
        .output_off(off), .motor_current(cur), .speed_pct(spd), .accelerating(acc),
        .decelerating(dec), .at_reference(atref));

    task automatic stop_test();
        if (bad_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            bad_count++;
        end
    endtask

    // one classic cycle; request held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= lanes;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            bad_count++;
            stop_test();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
    endtask

    task automatic hold();
        repeat (4) @(posedge clock);
    endtask

    task automatic ticks(input int n);
        repeat (n * TICK) @(posedge clock);
    endtask

    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd(8'(4 * i), rst_vals[i]);
        rd(8'h18, 32'h0);
        rd(8'h1c, 32'h0);
        rd(8'h40, 32'h0);
        // single byte lane leaves the other lanes untouched
        lanes = 4'h1;
        bus(1'b1, 8'h14, 32'hffff_ff50);
        lanes = 4'hf;
        rd(8'h14, 32'h50);
        // energy save only at steady speed, not zero, not sensorless
        load  <= 16'd100;
        phase <= 2'h1;
        bus(1'b1, 8'h14, 32'h14b4);
        hold();
        check(vred, 32'h14);
        phase <= 2'h0;
        hold();
        check(vred, 32'h0);
        phase <= 2'h1;
        bus(1'b1, 8'h00, 32'h4);
        hold();
        check(vred, 32'h0);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h14, 32'hb4);
        hold();
        check(vred, 32'h0);
        // stall per phase, rated 200 so 361 is just over 180 percent
        bus(1'b1, 8'h04, 32'hc8);
        load <= 16'd361;
        for (int m = 0; m < 3; m++)
            for (int p = 0; p < 3; p++) begin
                bus(1'b1, 8'h00, 32'(1 << (4 + m)));
                phase <= 2'(p);
                hold();
                check(stall, m == p);
            end
        bus(1'b1, 8'h00, 32'h70);
        phase <= 2'h0;
        hold();
        hold();
        check(stall, 1'b1);
        phase <= 2'h2;
        hold();
        check(stall, 1'b1);
        phase <= 2'h1;
        hold();
        check(stall, 1'b1);
        load <= 16'd360;
        hold();
        check(stall, 1'b0);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h04, 32'h64);
        load <= 16'd100;
        // alarm: 150 percent for 5 ticks, held after current drops
        bus(1'b1, 8'h0c, 32'h0596);
        load <= 16'd150;
        ticks(3);
        check(alarm, 1'b0);
        ticks(5);
        check(alarm, 1'b1);
        check(aux, 1'b0);
        bus(1'b1, 8'h00, 32'h100);
        hold();
        check(aux, 1'b1);
        check({off, fault}, 2'b00);
        load <= 16'd100;
        ticks(3);
        check(alarm, 1'b1);
        // clock enable low freezes the hold timer
        ce <= 1'b0;
        ticks(30);
        check(alarm, 1'b1);
        ce <= 1'b1;
        ticks(14);
        check(alarm, 1'b0);
        // overload trip: strictly above 180 percent for 4 ticks
        bus(1'b1, 8'h10, 32'h04b4);
        load <= 16'd180;
        ticks(8);
        check(fault, 1'b0);
        load <= 16'd181;
        ticks(7);
        check({off, fault}, 2'b11);
        load <= 16'd0;
        bus(1'b1, 8'h00, 32'h10000);
        hold();
        check({off, fault}, 2'b00);
        // thermal: forced cool at zero speed while accelerating, one minute at 150
        speed <= 8'h00;
        phase <= 2'h0;
        bus(1'b1, 8'h00, 32'h3);
        load <= 16'd150;
        ticks(580);
        check(ttrip, 1'b0);
        ticks(40);
        check(ttrip, 1'b1);
        check(off, 1'b1);
        check(ttrip, 1'b1);
        load <= 16'd0;
        bus(1'b1, 8'h00, 32'h10000);
        bus(1'b1, 8'h00, 32'h1);
        load <= 16'd150;
        ticks(300);
        check(ttrip, 1'b1);
        load <= 16'd0;
        bus(1'b1, 8'h00, 32'h10000);
        load <= 16'd150;
        ticks(620);
        check(ttrip, 1'b0);
        rd(8'h1c, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
